//--- verilog/cls_regs.svh
`ifndef CLS_REGS_SVH
`define CLS_REGS_SVH

// look-up table geometry
`define CLS_LUT_INPUTS   4
`define CLS_LUT_DEPTH    16
// storage element indices inside one slice
`define CLS_ELEM_X       0
`define CLS_ELEM_Y       1
`define CLS_ELEM_COUNT   2
// bit positions inside the set/reset function code
`define CLS_SRF_SET_BIT  0
`define CLS_SRF_RST_BIT  1
// value of the edge-detect history after reset, so no false edge is seen
`define CLS_EDGE_HIST_RST 1'b1

`endif

//--- verilog/cls_pkg.sv
package cls_pkg;

    // what the two look-up tables of the slice are doing
    typedef enum logic [4:0] {
        CLS_MODE_LOGIC  = 5'h01,  // plain 4-input functions
        CLS_MODE_RAM16S = 5'h02,  // two independent 16x1 single-port memories
        CLS_MODE_RAM16D = 5'h04,  // one 16x1 dual-port memory
        CLS_MODE_RAM32S = 5'h08,  // one 32x1 single-port memory
        CLS_MODE_RAM64S = 5'h10   // half of a 64x1 single-port memory
    } cls_ram_mode_e;

    // which forcing directions the set/reset logic may use
    typedef enum logic [1:0] {
        CLS_SRF_NONE  = 2'h0,
        CLS_SRF_SET   = 2'h1,
        CLS_SRF_RESET = 2'h2,
        CLS_SRF_BOTH  = 2'h3
    } cls_sr_func_e;

endpackage : cls_pkg

//--- verilog/cls_lut_ram.sv
`include "cls_regs.svh"

// one function generator: a 16x1 table read through four inputs and
// optionally written like a small memory
module cls_lut_ram
    import cls_pkg::*;
(
    input  wire logic                          core_clk,
    input  wire logic                          rst,
    input  wire logic [`CLS_LUT_DEPTH-1:0]     table_init,
    input  wire logic                          wr_en,
    input  wire logic [`CLS_LUT_INPUTS-1:0]    wr_addr,
    input  wire logic                          wr_data,
    input  wire logic [`CLS_LUT_INPUTS-1:0]    rd_addr,
    output logic                               rd_data
);

    logic [`CLS_LUT_DEPTH-1:0] cells;  // truth table / memory contents

    ////////////////////////////////////////////////////////////////////////
    // contents: loaded from the table at initialisation, written on demand
    always_ff @(posedge core_clk) begin
        if (rst) begin
            cells <= table_init;
        end else if (wr_en) begin
            cells[wr_addr] <= wr_data;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // read is purely a selection, same delay for any function stored
    assign rd_data = cells[rd_addr];

endmodule : cls_lut_ram

//--- verilog/cls_store.sv
`include "cls_regs.svh"

// one storage element: flip-flop or latch with forced states
module cls_store
    import cls_pkg::*;
(
    input  wire logic core_clk,
    input  wire logic rst,
    input  wire logic d,
    input  wire logic clk_edge,     // active edge of the slice clock seen
    input  wire logic clk_level,    // slice clock at its active level
    input  wire logic ce_act,       // clock enable after polarity
    input  wire logic set_act,      // a force-high request
    input  wire logic reset_act,    // a force-low request
    input  wire logic sr_async,     // forcing ignores the clock
    input  wire logic latch_mode,   // level-sensitive instead of edge
    input  wire logic init_val,     // value after initialisation
    output logic      q
);

    logic force_any;   // some force request is present
    logic force_val;   // what that force gives, low dominates
    logic latch_open;  // latch transparent this cycle

    assign force_any  = set_act | reset_act;
    assign force_val  = ~reset_act;
    assign latch_open = clk_level & ce_act;

    ////////////////////////////////////////////////////////////////////////
    // state update; the model samples every core clock, so a latch
    // follows its input with one core cycle of delay
    always_ff @(posedge core_clk) begin
        if (rst) begin
            q <= init_val;
        end else if (sr_async && force_any) begin
            q <= force_val;
        end else if (latch_mode) begin
            // transparent phase, sync forcing applies while open
            if (latch_open) begin
                q <= force_any ? force_val : d;
            end
        end else if (clk_edge) begin
            // sync forcing does not wait for the clock enable
            if (force_any) begin
                q <= force_val;
            end else if (ce_act) begin
                q <= d;
            end
        end
    end

endmodule : cls_store

//--- verilog/cls_slice.sv
`include "cls_regs.svh"


// behavioural model of one configurable logic slice
module cls_slice
    import cls_pkg::*;
(
    input  wire logic                       core_clk,
    input  wire logic                       rst,
    // shared storage controls, driven from fabric logic on core_clk
    input  wire logic                       slice_clk,
    input  wire logic                       slice_ce,
    input  wire logic                       set_reset_control,
    input  wire logic                       second_force_input,
    input  wire logic                       x_direct_input,
    // table inputs and contents
    input  wire logic [`CLS_LUT_INPUTS-1:0] f_in,
    input  wire logic [`CLS_LUT_INPUTS-1:0] g_in,
    input  wire logic [`CLS_LUT_DEPTH-1:0]  f_table,
    input  wire logic [`CLS_LUT_DEPTH-1:0]  g_table,
    // memory write data and wide-mux chain
    input  wire logic                       ram_wdata_f,
    input  wire logic                       ram_wdata_g,
    input  wire logic                       wide_sel,
    input  wire logic                       wide_lo_in,
    input  wire logic                       wide_hi_in,
    // configuration
    input  wire cls_ram_mode_e              cfg_ram_mode,
    input  wire logic                       cfg_upper_half,
    input  wire logic                       cfg_clk_inv,
    input  wire logic                       cfg_ce_inv,
    input  wire logic                       cfg_ce_used,
    input  wire logic                       cfg_sr_inv,
    input  wire logic                       cfg_rev_used,
    input  wire cls_sr_func_e               cfg_sr_func,
    input  wire logic                       cfg_sr_async,
    input  wire logic                       cfg_latch_mode,
    input  wire logic                       cfg_x_use_wide,
    input  wire logic                       cfg_y_use_wide,
    input  wire logic                       cfg_x_bypass,
    input  wire logic                       cfg_y_bypass,
    input  wire logic                       cfg_x_force_high,
    input  wire logic                       cfg_y_force_high,
    input  wire logic                       cfg_init_indep,
    input  wire logic                       cfg_x_init_high,
    input  wire logic                       cfg_y_init_high,
    // results
    output logic                            x_lut_out,
    output logic                            y_lut_out,
    output logic                            five_input_lut_mux,
    output logic                            wide_function_mux,
    output logic                            x_q,
    output logic                            y_q
);

    ////////////////////////////////////////////////////////////////////////
    // mode decode

    logic mode_logic;   // tables hold fixed functions
    logic mode_16s;     // two separate 16x1 memories
    logic mode_16d;     // dual-port 16x1
    logic mode_32s;     // 32x1, address bit 4 on the direct input
    logic mode_64s;     // 64x1, address bit 5 on the wide select
    logic mode_shared;  // both tables share the F address

    assign mode_logic  = (cfg_ram_mode == CLS_MODE_LOGIC);
    assign mode_16s    = (cfg_ram_mode == CLS_MODE_RAM16S);
    assign mode_16d    = (cfg_ram_mode == CLS_MODE_RAM16D);
    assign mode_32s    = (cfg_ram_mode == CLS_MODE_RAM32S);
    assign mode_64s    = (cfg_ram_mode == CLS_MODE_RAM64S);
    assign mode_shared = mode_32s | mode_64s;

    ////////////////////////////////////////////////////////////////////////
    // shared control polarity; inversion is a free xor on the clock, enable and set/reset inputs

    logic clk_eff;     // slice clock after polarity
    logic clk_hist;    // slice clock seen on the previous core cycle
    logic clk_edge;    // active edge of the slice clock
    logic ce_act;      // effective clock enable
    logic sr_act;      // effective set/reset (write enable in memory modes)
    logic rev_act;     // effective counter-state request

    assign clk_eff  = slice_clk ^ cfg_clk_inv;
    assign clk_edge = clk_eff & ~clk_hist;
    // an unused enable is tied active, as an open pin would be
    assign ce_act   = cfg_ce_used ? (slice_ce ^ cfg_ce_inv) : 1'b1;
    assign sr_act   = set_reset_control ^ cfg_sr_inv;
    // the second force only means something while set/reset is in use
    assign rev_act  = cfg_rev_used & (cfg_sr_func != CLS_SRF_NONE)
                      & second_force_input;

    // edge history; reset to the active level so release gives no edge
    always_ff @(posedge core_clk) begin
        if (rst) begin
            clk_hist <= `CLS_EDGE_HIST_RST;
        end else begin
            clk_hist <= clk_eff;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // memory write control; set/reset doubles as the write enable

    logic wr_fire;     // write enable held at an active edge
    logic half_ok;     // wide select matches this slice's half of 64x1
    logic bank_ok;     // address bank qualifier for shared modes
    logic f_we;        // write strobe for the F table
    logic g_we;        // write strobe for the G table

    assign wr_fire = clk_edge & sr_act & ~mode_logic;
    assign half_ok = ~mode_64s | (wide_sel == cfg_upper_half);
    assign bank_ok = mode_shared & half_ok;
    // F holds even half (bit 4 low), G the odd half in shared modes
    assign f_we    = wr_fire & ((mode_16s | mode_16d)
                     | (bank_ok & ~x_direct_input));
    assign g_we    = wr_fire & ((mode_16s | mode_16d)
                     | (bank_ok & x_direct_input));

    ////////////////////////////////////////////////////////////////////////
    // table address and data routing

    logic [`CLS_LUT_INPUTS-1:0] g_rd_addr;  // G read address
    logic [`CLS_LUT_INPUTS-1:0] g_wr_addr;  // G write address
    logic                       g_wr_data;  // G write data

    // dual-port: G reads its own address but writes at the F address
    assign g_rd_addr = mode_shared ? f_in : g_in;
    assign g_wr_addr = mode_16s ? g_in : f_in;
    // only two independent 16x1 memories take separate data
    assign g_wr_data = mode_16s ? ram_wdata_g : ram_wdata_f;

    // F table: read and write share f_in in every mode
    cls_lut_ram u_f_lut (
        .core_clk   (core_clk),
        .rst        (rst),
        .table_init (f_table),
        .wr_en      (f_we),
        .wr_addr    (f_in),
        .wr_data    (ram_wdata_f),
        .rd_addr    (f_in),
        .rd_data    (x_lut_out)
    );

    // G table: second read port when dual-ported
    cls_lut_ram u_g_lut (
        .core_clk   (core_clk),
        .rst        (rst),
        .table_init (g_table),
        .wr_en      (g_we),
        .wr_addr    (g_wr_addr),
        .wr_data    (g_wr_data),
        .rd_addr    (g_rd_addr),
        .rd_data    (y_lut_out)
    );

    ////////////////////////////////////////////////////////////////////////
    // wide-function multiplexers

    // joins both tables: a 5-input function or a 4:1 selector
    assign five_input_lut_mux = x_direct_input ? y_lut_out : x_lut_out;
    // chain stage: the neighbours' mux outputs come in on the two inputs,
    // so repeated stages cover up to eight tables
    assign wide_function_mux  = wide_sel ? wide_hi_in : wide_lo_in;

    ////////////////////////////////////////////////////////////////////////
    // storage element data sources

    logic x_d_source_mux;  // X table or joined result
    logic y_d_source_mux;  // Y table or chained result
    logic [`CLS_ELEM_COUNT-1:0] elem_d;       // per element data
    logic [`CLS_ELEM_COUNT-1:0] elem_force;   // per element forced level
    logic [`CLS_ELEM_COUNT-1:0] elem_init;    // per element initial value
    logic [`CLS_ELEM_COUNT-1:0] elem_q;       // per element state

    assign x_d_source_mux = cfg_x_use_wide ? five_input_lut_mux : x_lut_out;
    assign y_d_source_mux = cfg_y_use_wide ? wide_function_mux : y_lut_out;

    // the bypass skips the tables entirely, e.g. to register a direct pin
    assign elem_d[`CLS_ELEM_X] = cfg_x_bypass ? x_direct_input
                                              : x_d_source_mux;
    assign elem_d[`CLS_ELEM_Y] = cfg_y_bypass ? second_force_input
                                              : y_d_source_mux;

    assign elem_force[`CLS_ELEM_X] = cfg_x_force_high;
    assign elem_force[`CLS_ELEM_Y] = cfg_y_force_high;

    // power-up copies the forced level unless set on its own
    assign elem_init[`CLS_ELEM_X] = cfg_init_indep ? cfg_x_init_high
                                                   : cfg_x_force_high;
    assign elem_init[`CLS_ELEM_Y] = cfg_init_indep ? cfg_y_init_high
                                                   : cfg_y_force_high;

    ////////////////////////////////////////////////////////////////////////
    // set/reset function gating

    logic set_allowed;  // set direction enabled
    logic rst_allowed;  // reset direction enabled
    logic sr_force;     // set/reset may force (not a write enable now)

    assign set_allowed = cfg_sr_func[`CLS_SRF_SET_BIT];
    assign rst_allowed = cfg_sr_func[`CLS_SRF_RST_BIT];
    // in memory modes the same pin is the write enable, never a force
    assign sr_force    = sr_act & mode_logic;

    ////////////////////////////////////////////////////////////////////////
    // the two storage elements, sharing all controls

    for (genvar e = 0; e < `CLS_ELEM_COUNT; e++) begin : g_elem
        logic want_high;  // some request drives this element high
        logic want_low;   // some request drives this element low

        // set/reset gives the configured level, the second input the other
        assign want_high = (sr_force & elem_force[e])
                           | (rev_act & ~elem_force[e]);
        assign want_low  = (sr_force & ~elem_force[e])
                           | (rev_act & elem_force[e]);

        // one clock, one enable, one set/reset for both elements
        cls_store u_store (
            .core_clk   (core_clk),
            .rst        (rst),
            .d          (elem_d[e]),
            .clk_edge   (clk_edge),
            .clk_level  (clk_eff),
            .ce_act     (ce_act),
            .set_act    (want_high & set_allowed),
            .reset_act  (want_low & rst_allowed),
            .sr_async   (cfg_sr_async),
            .latch_mode (cfg_latch_mode),
            .init_val   (elem_init[e]),
            .q          (elem_q[e])
        );
    end

    // registered memory read: same edge that writes the tables
    assign x_q = elem_q[`CLS_ELEM_X];
    assign y_q = elem_q[`CLS_ELEM_Y];

endmodule : cls_slice

//--- sim/cls_slice_chk.sv
// watches the slice ports: mux selection, capture, hold and forcing
module cls_slice_chk
    import cls_pkg::*;
(
    input wire logic          core_clk,
    input wire logic          rst,
    input wire logic          slice_clk,
    input wire logic          slice_ce,
    input wire logic          set_reset_control,
    input wire logic          second_force_input,
    input wire logic          x_direct_input,
    input wire logic          wide_sel,
    input wire logic          wide_lo_in,
    input wire logic          wide_hi_in,
    input wire cls_ram_mode_e cfg_ram_mode,
    input wire logic          cfg_clk_inv,
    input wire logic          cfg_ce_inv,
    input wire logic          cfg_ce_used,
    input wire logic          cfg_sr_inv,
    input wire logic          cfg_rev_used,
    input wire cls_sr_func_e  cfg_sr_func,
    input wire logic          cfg_sr_async,
    input wire logic          cfg_latch_mode,
    input wire logic          cfg_x_use_wide,
    input wire logic          cfg_x_bypass,
    input wire logic          cfg_x_force_high,
    input wire logic          x_lut_out,
    input wire logic          y_lut_out,
    input wire logic          five_input_lut_mux,
    input wire logic          wide_function_mux,
    input wire logic          x_q,
    input wire logic          y_q
);
    timeunit 1ns;
    timeprecision 1ps;

    ////////////////////////////////////////////////////////////////////////////////
    logic      prev_eff;                                          // clock level a cycle ago
    wire logic clk_eff = slice_clk ^ cfg_clk_inv;                 // clock at active level
    wire logic ce_eff  = ~cfg_ce_used | (slice_ce ^ cfg_ce_inv);  // unused enable is on
    wire logic sr_eff  = set_reset_control ^ cfg_sr_inv;          // force request
    wire logic rev_eff = cfg_rev_used & second_force_input;       // opposite force
    wire logic edge_w  = clk_eff & ~prev_eff;                     // active edge seen
    wire logic logic_m = cfg_ram_mode == CLS_MODE_LOGIC;
    wire logic both_m  = cfg_sr_func == CLS_SRF_BOTH;
    wire logic none_m  = cfg_sr_func == CLS_SRF_NONE;
    wire logic flop_m  = logic_m & ~cfg_latch_mode & ~cfg_sr_async;

    // history starts high, so a clock held active over reset gives no edge
    always_ff @(posedge core_clk) begin
        prev_eff <= rst | clk_eff;
    end

    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (rst);

    ////////////////////////////////////////////////////////////////////////////////
    f5_mux_a: assert property (logic_m |->
        five_input_lut_mux == (x_direct_input ? y_lut_out : x_lut_out))
        else $error("five input mux differs from selected table");
    wide_mux_a: assert property (logic_m |->
        wide_function_mux == (wide_sel ? wide_hi_in : wide_lo_in))
        else $error("wide mux differs from selected input");
    flop_capture_a: assert property (flop_m & none_m & edge_w & ce_eff & cfg_x_bypass
        & ~cfg_x_use_wide |=> x_q == $past(x_direct_input))
        else $error("flip-flop missed its data on an active edge");
    ce_hold_a: assert property (logic_m & ~cfg_latch_mode & none_m & ~ce_eff
        |=> $stable(x_q) && $stable(y_q))
        else $error("element changed with enable off");
    sync_force_a: assert property (flop_m & edge_w & sr_eff & ~rev_eff & both_m
        |=> x_q == $past(cfg_x_force_high))
        else $error("sync force gave wrong level");
    reset_wins_a: assert property (flop_m & edge_w & sr_eff & rev_eff & both_m
        |=> !x_q && !y_q)
        else $error("set won over reset");
    async_force_a: assert property (logic_m & cfg_sr_async & sr_eff & ~rev_eff & both_m
        |=> x_q == $past(cfg_x_force_high))
        else $error("async force did not act");
    latch_pass_a: assert property (logic_m & cfg_latch_mode & clk_eff & ce_eff & none_m
        & cfg_x_bypass & ~cfg_x_use_wide |=> x_q == $past(x_direct_input))
        else $error("open latch did not pass data");
    latch_hold_a: assert property (cfg_latch_mode & ~clk_eff & ~cfg_sr_async
        |=> $stable(x_q))
        else $error("closed latch changed");
endmodule : cls_slice_chk

bind cls_slice cls_slice_chk u_chk (.*);

//--- sim/test_configurable_logic_slice.sv
module test_configurable_logic_slice
    import cls_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;

    ////////////////////////////////////////////////////////////////////////////////
    logic core_clk, rst, slice_clk, slice_ce, set_reset_control, second_force_input;
    logic x_direct_input, ram_wdata_f, ram_wdata_g, wide_sel, wide_lo_in, wide_hi_in;
    logic cfg_upper_half, cfg_clk_inv, cfg_ce_inv, cfg_ce_used, cfg_sr_inv, cfg_rev_used;
    logic cfg_sr_async, cfg_latch_mode, cfg_x_use_wide, cfg_y_use_wide, cfg_x_bypass;
    logic cfg_y_bypass, cfg_x_force_high, cfg_y_force_high, cfg_init_indep;
    logic cfg_x_init_high, cfg_y_init_high, x_lut_out, y_lut_out;
    logic five_input_lut_mux, wide_function_mux, x_q, y_q;
    logic [3:0]    f_in, g_in;       // table inputs
    logic [15:0]   f_table, g_table; // contents loaded at reset
    cls_ram_mode_e cfg_ram_mode;
    cls_sr_func_e  cfg_sr_func;
    int            miscompares, samples_checked;
    // packed force cases: sr, rev, func, x data, y data, x expected, y expected
    logic [7:0]    force_case [6] = '{8'hb6, 8'h97, 8'ha4, 8'h8a, 8'hfc, 8'h79};

    cls_slice dut (.*);  // every port meets the bench signal of its own name

    // model clock, 4 ns period
    initial begin
        core_clk = 1'b0;
        forever #2 core_clk = ~core_clk;
    end

    ////////////////////////////////////////////////////////////////////////////////
    task automatic check(input string what, input logic seen, input logic expected);
        samples_checked++;
        if (seen !== expected) begin
            miscompares++;
            $display("CHECK FAILED %s expected %b seen %b", what, expected, seen);
        end
    endtask : check

    task automatic qchk(input logic ex, input logic ey);
        check("x_q", x_q, ex);
        check("y_q", y_q, ey);
    endtask : qchk

    task automatic cyc(input int n);
        repeat (n) @(posedge core_clk);
    endtask : cyc

    // one active slice clock edge, back idle a cycle later; outputs settled on return
    task automatic pulse;
        cyc(1);
        slice_clk <= ~cfg_clk_inv;
        cyc(1);
        slice_clk <= cfg_clk_inv;
        cyc(1);
        #1;
    endtask : pulse

    task automatic do_reset;
        cyc(1);
        rst <= 1'b1;
        cyc(2);
        rst <= 1'b0;
        cyc(1);
        #1;
    endtask : do_reset

    task automatic complete_run;
        $display("miscompares %0d samples_checked %0d", miscompares, samples_checked);
        if (miscompares == 0 && samples_checked > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask : complete_run

    // a hang is cut short here and counts as a mismatch
    initial begin
        cyc(2000);
        miscompares++;
        complete_run();
    end

    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        logic [7:0] c;
        miscompares = 0;
        samples_checked = 0;
        {slice_clk, slice_ce, set_reset_control, second_force_input, x_direct_input,
         ram_wdata_f, ram_wdata_g, wide_sel, wide_lo_in, wide_hi_in, cfg_upper_half,
         cfg_clk_inv, cfg_ce_inv, cfg_ce_used, cfg_sr_inv, cfg_rev_used, cfg_sr_async,
         cfg_latch_mode, cfg_x_use_wide, cfg_y_use_wide, cfg_x_bypass, cfg_y_bypass,
         cfg_y_force_high, cfg_init_indep, cfg_x_init_high, cfg_y_init_high} <= '0;
        f_in <= 4'h0;
        g_in <= 4'h0;
        f_table <= 16'h6a5c;
        g_table <= 16'h93e1;
        cfg_ram_mode <= CLS_MODE_LOGIC;
        cfg_sr_func <= CLS_SRF_NONE;
        cfg_x_force_high <= 1'b1;
        rst <= 1'b1;
        cyc(2);
        rst <= 1'b0;
        cyc(1);
        #1;
        qchk(1'b1, 1'b0);
        // every table entry, with both muxes selecting
        for (int i = 0; i < 16; i++) begin
            cyc(1);
            f_in <= i[3:0];
            g_in <= i[3:0];
            x_direct_input <= i[0];
            wide_sel <= i[1];
            wide_lo_in <= i[2];
            wide_hi_in <= i[3];
            #1;
            check("x_lut_out", x_lut_out, f_table[i]);
            check("y_lut_out", y_lut_out, g_table[i]);
            check("five_mux", five_input_lut_mux, i[0] ? g_table[i] : f_table[i]);
            check("wide_mux", wide_function_mux, i[1] ? i[3] : i[2]);
        end
        // initial value chosen apart from the forced level
        cyc(1);
        cfg_init_indep <= 1'b1;
        cfg_y_init_high <= 1'b1;
        do_reset();
        qchk(1'b0, 1'b1);
        cyc(1);
        cfg_x_bypass <= 1'b1;
        cfg_y_bypass <= 1'b1;
        x_direct_input <= 1'b1;
        second_force_input <= 1'b0;
        pulse();
        qchk(1'b1, 1'b0);
        cyc(1);
        cfg_x_bypass <= 1'b0;
        cfg_y_bypass <= 1'b0;
        f_in <= 4'h0;
        g_in <= 4'h0;
        pulse();
        qchk(f_table[0], g_table[0]);
        // enable off holds, inverted enable captures, unused enable captures
        cyc(1);
        cfg_x_bypass <= 1'b1;
        cfg_ce_used <= 1'b1;
        x_direct_input <= 1'b1;
        pulse();
        check("x_q", x_q, 1'b0);
        cyc(1);
        cfg_ce_inv <= 1'b1;
        pulse();
        check("x_q", x_q, 1'b1);
        cyc(1);
        cfg_ce_used <= 1'b0;
        cfg_ce_inv <= 1'b0;
        x_direct_input <= 1'b0;
        pulse();
        check("x_q", x_q, 1'b0);
        // falling slice clock as the active edge; level unchanged at the swap
        cyc(1);
        cfg_clk_inv <= 1'b1;
        slice_clk <= 1'b1;
        x_direct_input <= 1'b1;
        pulse();
        check("x_q", x_q, 1'b1);
        cyc(1);
        cfg_clk_inv <= 1'b0;
        slice_clk <= 1'b0;
        cfg_rev_used <= 1'b1;
        foreach (force_case[k]) begin
            c = force_case[k];
            cyc(1);
            set_reset_control <= c[7];
            second_force_input <= c[6];
            cfg_sr_func <= cls_sr_func_e'(c[5:4]);
            x_direct_input <= c[3];
            g_in <= {3'h0, ~c[2]};
            pulse();
            qchk(c[1], c[0]);
        end
        // asynchronous force through an inverted control, no clock, enable off
        cyc(1);
        set_reset_control <= 1'b0;
        second_force_input <= 1'b0;
        cfg_sr_inv <= 1'b1;
        cfg_sr_async <= 1'b1;
        cfg_sr_func <= CLS_SRF_BOTH;
        cfg_ce_used <= 1'b1;
        cyc(2);
        #1;
        qchk(1'b1, 1'b0);
        cyc(1);
        cfg_sr_inv <= 1'b0;
        cfg_sr_async <= 1'b0;
        cfg_sr_func <= CLS_SRF_NONE;
        cfg_ce_used <= 1'b0;
        // latch: open passes data, closed holds
        cyc(1);
        cfg_latch_mode <= 1'b1;
        x_direct_input <= 1'b0;
        cyc(1);
        slice_clk <= 1'b1;
        cyc(2);
        #1;
        check("x_q", x_q, 1'b0);
        cyc(1);
        x_direct_input <= 1'b1;
        cyc(2);
        #1;
        check("x_q", x_q, 1'b1);
        cyc(1);
        slice_clk <= 1'b0;
        x_direct_input <= 1'b0;
        cyc(2);
        #1;
        check("x_q", x_q, 1'b1);
        cyc(1);
        cfg_latch_mode <= 1'b0;
        // two single-port memories; the element registers the old word
        cyc(1);
        cfg_ram_mode <= CLS_MODE_RAM16S;
        cfg_x_bypass <= 1'b0;
        f_in <= 4'h5;
        g_in <= 4'h9;
        ram_wdata_f <= ~f_table[5];
        ram_wdata_g <= ~g_table[9];
        set_reset_control <= 1'b1;
        pulse();
        check("x_lut_out", x_lut_out, ~f_table[5]);
        check("y_lut_out", y_lut_out, ~g_table[9]);
        check("x_q", x_q, f_table[5]);
        cyc(1);
        set_reset_control <= 1'b0;
        ram_wdata_f <= f_table[5];
        pulse();
        check("x_lut_out", x_lut_out, ~f_table[5]);
        // dual port: write at the first address, read the copy at the second
        cyc(1);
        cfg_ram_mode <= CLS_MODE_RAM16D;
        f_in <= 4'h6;
        g_in <= 4'h2;
        ram_wdata_f <= 1'b0;
        set_reset_control <= 1'b1;
        pulse();
        check("x_lut_out", x_lut_out, 1'b0);
        check("y_lut_out", y_lut_out, g_table[2]);
        cyc(1);
        set_reset_control <= 1'b0;
        g_in <= 4'h6;
        #1;
        check("y_lut_out", y_lut_out, 1'b0);
        // 32 words: the direct input picks the upper table
        cyc(1);
        cfg_ram_mode <= CLS_MODE_RAM32S;
        x_direct_input <= 1'b1;
        f_in <= 4'hc;
        ram_wdata_f <= ~g_table[12];
        set_reset_control <= 1'b1;
        pulse();
        check("five_mux", five_input_lut_mux, ~g_table[12]);
        cyc(1);
        set_reset_control <= 1'b0;
        x_direct_input <= 1'b0;
        #1;
        check("five_mux", five_input_lut_mux, f_table[12]);
        // 64 words: only the half named by the wide select takes the write
        cyc(1);
        cfg_ram_mode <= CLS_MODE_RAM64S;
        wide_sel <= 1'b1;
        f_in <= 4'h1;
        ram_wdata_f <= ~f_table[1];
        set_reset_control <= 1'b1;
        pulse();
        check("five_mux", five_input_lut_mux, f_table[1]);
        cyc(1);
        wide_sel <= 1'b0;
        pulse();
        check("five_mux", five_input_lut_mux, ~f_table[1]);
        complete_run();
    end
endmodule : test_configurable_logic_slice
